// ### shared/ddrtr_pkg.sv
// Package of constants and types for the DDR2 device-side timing keeper
package ddrtr_pkg;
  // Clock and timing figures
  localparam int    SYS_CLK_PERIOD_PS       = 4000;
  localparam int    ACTIVE_TO_PRECHARGE_MIN_PS = 40000;
  localparam int    SINGLE_BANK_PRECHARGE_PERIOD_PS = 15000;
  localparam int    RAS_CYC = (ACTIVE_TO_PRECHARGE_MIN_PS + SYS_CLK_PERIOD_PS - 1)
                              / SYS_CLK_PERIOD_PS;
  localparam int    RP_CYC  = (SINGLE_BANK_PRECHARGE_PERIOD_PS + SYS_CLK_PERIOD_PS - 1)
                              / SYS_CLK_PERIOD_PS;
  // Mode register write-recovery field, bits 11:9
  localparam int    WR_FIELD_LSB            = 9;
  localparam int    WR_FIELD_W              = 3;
  // Termination turn-off: 2.5 clocks -> 2 full cycles plus half
  localparam int    TERM_OFF_HALF_CLOCKS    = 5;
  localparam int    TERM_OFF_CYC            = TERM_OFF_HALF_CLOCKS / 2;
  // Data lanes, bank count and counter width
  localparam int    LANE_BITS               = 8;
  localparam int    LANES                   = 10;
  localparam int    NUM_BANKS               = 8;
  localparam int    CNT_W                   = 8;
  // Command codes
  typedef enum logic [2:0] {
    DDRTR_CMD_NOP  = 3'h0,
    DDRTR_CMD_ACT  = 3'h1,
    DDRTR_CMD_RDAP = 3'h2,
    DDRTR_CMD_WRAP = 3'h3,
    DDRTR_CMD_MRS  = 3'h4
  } ddrtr_cmd_e;
  // Command carrier
  typedef struct packed {
    logic             valid;
    ddrtr_cmd_e       cmd;
    logic [2:0]       bank;
    logic [12:0]      addr;
  } ddrtr_cmd_s;
endpackage

// ### verilog/ddrtr_core.sv
// Device-side auto-precharge timing, write-recovery field and termination-off delay
`timescale 1ns/1ps
module ddrtr_core (
  input  wire logic                 sys_clk_in,     // Command clock
  input  wire logic                 reset_n_in,     // Sync reset, active low
  input  wire ddrtr_pkg::ddrtr_cmd_s cmd_in,        // Decoded command
  input  wire logic                 term_ctrl_in,   // Termination control
  input  wire logic [79:0]          wdata_in,       // Write data
  input  wire logic [9:0]           strobe_in,      // Per-lane strobes
  output logic [7:0]                precharge_out,  // Internal precharge per bank
  output logic [3:0]                wr_clocks_out,  // Programmed write recovery
  output logic                      term_on_out,    // Termination enabled
  output logic [79:0]               lane_data_out   // Strobe-captured data
);
  import ddrtr_pkg::*;

  // ****************************************
  // State
  // ****************************************
  // ras_cnt:  per-bank lockout left after an activate
  // ap_cnt:   per-bank write recovery left after a write with auto-precharge
  // ap_pend:  auto-precharge accepted, internal precharge not yet fired
  // pre:      one-cycle internal precharge strobe per bank
  // wr_field: write-recovery code from the last mode register load
  // off_cnt:  termination clocks left after control falls
  // Lockout and recovery counters run in parallel, so an early
  // auto-precharge simply waits for whichever of the two ends later.
  typedef struct packed {
    logic [NUM_BANKS-1:0][CNT_W-1:0] ras_cnt;
    logic [NUM_BANKS-1:0][CNT_W-1:0] ap_cnt;
    logic [NUM_BANKS-1:0]            ap_pend;
    logic [NUM_BANKS-1:0]            pre;
    logic [WR_FIELD_W-1:0]           wr_field;
    logic [1:0]                      off_cnt;
    logic                            term_on;
    logic [79:0]                     lane;
  } ddrtr_state_s;

  ddrtr_state_s st_reg;
  ddrtr_state_s st_next;
  logic [3:0]   wr_clocks;

  // Elaboration check: bank decode and lane loop assume this geometry
  generate
    if (NUM_BANKS != 8 || LANES * LANE_BITS != 80) begin : g_bad_geometry
      $error("ddrtr_core: unsupported geometry");
    end
  endgenerate

  // Picosecond limits become clock counts through the average
  // period held in the package; the counts round up, never down.
  // No refresh-interval watchdog: refresh bursts pass untouched
  // and a long gap between refreshes raises nothing here.

  // write recovery decode: code k gives k+1 clocks
  // Code zero still gives one clock, so the recovery load never underflows
  assign wr_clocks = 4'(st_reg.wr_field) + 4'h1;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    st_next.pre = '0;
    if (cmd_in.valid && cmd_in.cmd == DDRTR_CMD_MRS) begin
      st_next.wr_field = cmd_in.addr[WR_FIELD_LSB +: WR_FIELD_W];
    end
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (st_reg.ras_cnt[b] != '0) begin
        st_next.ras_cnt[b] = st_reg.ras_cnt[b] - CNT_W'(1);
      end
      if (st_reg.ap_cnt[b] != '0) begin
        st_next.ap_cnt[b] = st_reg.ap_cnt[b] - CNT_W'(1);
      end
      // hold precharge until ras lockout and write recovery have both expired
      if (st_reg.ap_pend[b] && st_reg.ras_cnt[b] == '0 && st_reg.ap_cnt[b] == '0) begin
        st_next.pre[b]     = 1'b1;
        st_next.ap_pend[b] = 1'b0;
      end
      if (cmd_in.valid && cmd_in.bank == 3'(b)) begin
        if (cmd_in.cmd == DDRTR_CMD_ACT) begin
          st_next.ras_cnt[b] = CNT_W'(RAS_CYC - 1);
        end else if (cmd_in.cmd == DDRTR_CMD_RDAP) begin
          st_next.ap_pend[b] = 1'b1;
        end else if (cmd_in.cmd == DDRTR_CMD_WRAP) begin
          // write recovery delays the internal precharge
          st_next.ap_pend[b] = 1'b1;
          st_next.ap_cnt[b]  = CNT_W'(wr_clocks) - CNT_W'(1);
        end
      end
    end
    // termination off 2.5 clocks after deassert
    if (term_ctrl_in) begin
      st_next.term_on = 1'b1;
      st_next.off_cnt = 2'(TERM_OFF_CYC);
    end else if (st_reg.term_on) begin
      if (st_reg.off_cnt == 2'h0) begin
        st_next.term_on = 1'b0;
      end else begin
        st_next.off_cnt = st_reg.off_cnt - 2'h1;
      end
    end
    // each strobe captures its own byte lane
    for (int l = 0; l < LANES; l++) begin
      if (strobe_in[l]) begin
        st_next.lane[l*LANE_BITS +: LANE_BITS] = wdata_in[l*LANE_BITS +: LANE_BITS];
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign precharge_out = st_reg.pre;
  assign wr_clocks_out = wr_clocks;
  assign term_on_out   = st_reg.term_on;
  assign lane_data_out = st_reg.lane;

  // ****************************************
  // Assertions
  // ****************************************
  generate
    for (genvar g = 0; g < NUM_BANKS; g++) begin : g_chk
      a_ras_lockout_hold: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (cmd_in.valid && cmd_in.cmd == DDRTR_CMD_ACT && cmd_in.bank == 3'(g))
        |=> !precharge_out[g][*8])
        else $error("precharge before active_to_precharge_min");
    end
  endgenerate

  a_wr_field_load: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (cmd_in.valid && cmd_in.cmd == DDRTR_CMD_MRS)
    |=> wr_clocks_out == 4'($past(cmd_in.addr[11:9])) + 4'h1)
    else $error("write recovery field not loaded");

  sequence s_term_fall;
    term_on_out && !term_ctrl_in && $past(term_ctrl_in);
  endsequence
  a_term_off_delay: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    s_term_fall ##0 !term_ctrl_in[*3] |=> !term_on_out)
    else $error("termination off delay wrong");

  a_lane_capture: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    strobe_in[0] |=> lane_data_out[7:0] == $past(wdata_in[7:0]))
    else $error("lane zero not captured");

  // ****************************************
  // Further checks
  // ****************************************
  generate
    for (genvar g = 0; g < NUM_BANKS; g++) begin : g_pulse
      // Activate and auto-precharge read on this bank
      sequence s_act_here;
        cmd_in.valid && cmd_in.cmd == DDRTR_CMD_ACT && cmd_in.bank == 3'(g);
      endsequence
      sequence s_rdap_here;
        cmd_in.valid && cmd_in.cmd == DDRTR_CMD_RDAP && cmd_in.bank == 3'(g);
      endsequence
      // internal precharge fires as soon as the lockout ends
      a_ras_release: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        s_act_here ##2 s_rdap_here |-> ##9 precharge_out[g])
        else $error("internal precharge late after lockout");
      // internal precharge is a single-cycle strobe
      a_pre_one_cycle: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        precharge_out[g] |=> !precharge_out[g])
        else $error("internal precharge held longer than one cycle");
      // eight recovery clocks defer the precharge after a write
      a_wrap_recovery: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (cmd_in.valid && cmd_in.cmd == DDRTR_CMD_WRAP && cmd_in.bank == 3'(g)
         && wr_clocks_out == 4'h8) |=> !precharge_out[g][*7])
        else $error("precharge before write recovery");
    end
  endgenerate

  // recovery clocks change only on a mode register load
  a_wr_field_hold: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    !(cmd_in.valid && cmd_in.cmd == DDRTR_CMD_MRS) |=> $stable(wr_clocks_out))
    else $error("write recovery changed without a mode load");

  // termination still on two edges after control falls
  a_term_hold_on: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    s_term_fall ##1 !term_ctrl_in |-> term_on_out)
    else $error("termination dropped too early");

endmodule // ddrtr_core

// ### verif/ddrtr_ctrl_model.sv
// Controller model driving one-cycle commands into the device
`timescale 1ns/1ps
module ddrtr_ctrl_model (
  input  wire logic             clk_in,   // Command clock
  output ddrtr_pkg::ddrtr_cmd_s cmd_out   // Command to device
);
  import ddrtr_pkg::*;
  // Idle bus at start
  initial cmd_out = '0;
  // one idle cycle between commands; few activates per run
  // no explicit precharge; only auto-precharge commands
  // refresh, clock enable and strobe timing not modelled
  task automatic issue(input ddrtr_cmd_e c, input logic [2:0] b, input logic [12:0] a);
    @(posedge clk_in);
    #1 cmd_out = '{1'b1, c, b, a};
    @(posedge clk_in);
    // Idle fields inverted so stale values never look valid
    #1 cmd_out = '{1'b0, DDRTR_CMD_NOP, ~b, ~a};
  endtask
endmodule // ddrtr_ctrl_model

// ### verif/ddrtr_core_tb.sv
// Self-checking bench for the device-side timing keeper
`timescale 1ns/1ps
module ddrtr_core_tb;
  import ddrtr_pkg::*;
  logic        sys_clk_in, reset_n_in, term_ctrl_in, term_on_out;
  logic [79:0] wdata_in, lane_data_out;
  logic [9:0]  strobe_in;
  logic [7:0]  precharge_out;
  logic [3:0]  wr_clocks_out;
  ddrtr_cmd_s  cmd;
  int          failures = 0;
  int          tests_run = 0;
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; \
  $display("mismatch t=%0t got %0h exp %0h", $time, a, e); end end
  ddrtr_ctrl_model u_ctrl (.clk_in(sys_clk_in), .cmd_out(cmd));
  ddrtr_core DUT (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .cmd_in(cmd),
    .term_ctrl_in(term_ctrl_in), .wdata_in(wdata_in), .strobe_in(strobe_in),
    .precharge_out(precharge_out), .wr_clocks_out(wr_clocks_out),
    .term_on_out(term_on_out), .lane_data_out(lane_data_out));
  // Clock and time-zero input values
  initial begin
    sys_clk_in = 0;
    reset_n_in = 0;
    term_ctrl_in = 0;
    wdata_in = '0;
    strobe_in = '0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  // Report counts and end the run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Auto-precharge right after activate waits out the lockout
  task automatic ap_lockout(input ddrtr_cmd_e c, input logic [2:0] b);
    int n;
    u_ctrl.issue(DDRTR_CMD_ACT, b, 13'h0000);
    u_ctrl.issue(c, b, 13'h0400);
    for (n = 2; n < 30 && precharge_out[b] !== 1'b1; n++) begin
      @(posedge sys_clk_in);
      #1;
    end
    `CHK(n >= RAS_CYC && n <= RAS_CYC + 2, 1'b1)
    `CHK(precharge_out, 8'h01 << b)
    if (n == 30) complete_run();
  endtask
  // Every write-recovery code lands in the field
  task automatic check_wr_field();
    for (int k = 0; k < 8; k++) begin
      u_ctrl.issue(DDRTR_CMD_MRS, 3'h0, 13'(k << 9) | 13'h01FF);
      `CHK(wr_clocks_out, 4'(k + 1))
    end
  endtask
  // Termination drops on the third edge after control falls
  task automatic check_term_off();
    term_ctrl_in = 1;
    repeat (4) @(posedge sys_clk_in);
    #1 term_ctrl_in = 0;
    `CHK(term_on_out, 1'b1)
    repeat (2) @(posedge sys_clk_in);
    #1 `CHK(term_on_out, 1'b1)
    @(posedge sys_clk_in);
    #1 `CHK(term_on_out, 1'b0)
  endtask
  // Each strobe captures only its own byte lane
  task automatic check_lanes();
    for (int n = 0; n < 10; n++) begin
      wdata_in = {10{8'h5A + 8'(n)}};
      strobe_in = 10'h001 << n;
      @(posedge sys_clk_in);
      #1;
    end
    strobe_in = '0;
    for (int n = 0; n < 10; n++) `CHK(lane_data_out[8*n +: 8], 8'h5A + 8'(n))
  endtask
  // Late write with auto-precharge waits only the recovery clocks
  task automatic wrap_recovery();
    int n;
    u_ctrl.issue(DDRTR_CMD_ACT, 3'h3, 13'h0000);
    repeat (12) @(posedge sys_clk_in);
    #1 `CHK(precharge_out, 8'h00)
    u_ctrl.issue(DDRTR_CMD_WRAP, 3'h3, 13'h0400);
    n = 0;
    while (n < 30 && precharge_out[3] !== 1'b1) begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end
    `CHK(n, 8)
    `CHK(precharge_out, 8'h08)
    if (n == 30) complete_run();
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk_in);
    #1 reset_n_in = 1;
    `CHK(wr_clocks_out, 4'h1)
    `CHK(precharge_out, 8'h00)
    ap_lockout(DDRTR_CMD_RDAP, 3'h0);
    check_wr_field();
    ap_lockout(DDRTR_CMD_WRAP, 3'h7);
    wrap_recovery();
    check_term_off();
    check_lanes();
    complete_run();
  end
endmodule // ddrtr_core_tb
